//--- src/brg_pkg.sv
package brg_pkg;

    // ************************************************************
    // register map, byte addresses
    // ************************************************************
    localparam logic [3:0] ADDR_RELOAD = 4'h0;
    localparam logic [3:0] ADDR_BUFFER = 4'h4;
    localparam logic [3:0] ADDR_CONTROL = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;

    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_I2C_BIT = 1;
    localparam int STS_RUNNING_BIT = 0;
    localparam int STS_SCLK_BIT = 1;
    localparam int STS_WAIT_BIT = 2;
    localparam int STS_COUNT_LSB = 8;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] BUFFER_RESET = 8'h00;

    // ************************************************************
    // timing: two counter steps per instruction cycle of four clocks
    // ************************************************************
    localparam int CLKS_PER_INSN = 4;
    localparam int STEPS_PER_INSN = 2;
    localparam int CLKS_PER_STEP = CLKS_PER_INSN / STEPS_PER_INSN;
    localparam int HALVES_PER_BYTE = 16;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_COUNT = 2'b01,
        ST_WAIT_HIGH = 2'b10
    } run_state_t;

endpackage : brg_pkg

//--- src/serial_clock_divider.sv
`timescale 1ns/10ps

module serial_clock_divider
    import brg_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic load,
    input wire logic step,
    input wire logic [WIDTH-1:0] reload_value,
    // state
    output logic [WIDTH-1:0] count,
    output logic at_zero
);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;

    initial
    begin
        if (WIDTH < 1) $error("divider width must be at least one");
    end

    always_comb
    begin
        count_nxt = count_r;
        if (load)
        begin
            count_nxt = reload_value;
        end
        else if (step && count_r != '0)
        begin
            count_nxt = count_r - WIDTH'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end

    assign count = count_r;
    assign at_zero = (count_r == '0);

endmodule : serial_clock_divider

//--- src/serial_port_baud_rate_generator.sv
// Overview of operation
// - one counter makes serial clock, both master modes
// - software sets reload; counter loads on reload
// - buffer write starts the countdown
// - stops after the byte; clock pin holds level
// - reload twice per period, mode decides when
// - serial clock equals clk over four(reload+1) in spi mode; in i2c the high half also waits for the pin
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps

module serial_port_baud_rate_generator
    import brg_pkg::*;
#(
    parameter int RELOAD_WIDTH = 8
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // serial clock pin
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    // to the shift logic
    output logic [7:0] serial_shift_buffer,
    output logic sclk_edge
);

    // ************************************************************
    // bus slave: one wait state, then read data and write commit
    // ************************************************************
    logic ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [7:0] brg_reload_value_r, reload_nxt;
    logic [7:0] buffer_r, buffer_nxt;
    logic enable_r, enable_nxt;
    logic i2c_r, i2c_nxt;
    logic wr_commit, buf_write;

    initial
    begin
        if (RELOAD_WIDTH != 8) $error("reload register is eight bits wide");
    end
    assign waitrequest = (read || write) && !ack_r;
    assign wr_commit = write && ack_r && byteenable[0];
    assign buf_write = wr_commit && address == ADDR_BUFFER;

    // ************************************************************
    // run control and serial clock state
    // ************************************************************
    run_state_t state_r, state_nxt;
    logic sclk_r, sclk_nxt;
    logic [3:0] half_cnt_r, half_cnt_nxt;
    logic step_r, step_nxt;
    logic reload_strobe, at_zero, half_done;
    logic [7:0] count;
    logic s1_r, s2_r, s3_r;
    logic pin_high_r, pin_high_nxt;

    always_comb
    begin
        ack_nxt = (read || write) && !ack_r;
        rdata_nxt = rdata_r;
        reload_nxt = brg_reload_value_r;
        buffer_nxt = buffer_r;
        enable_nxt = enable_r;
        i2c_nxt = i2c_r;
        if (read && !ack_r)
        begin
            unique case (address)
                ADDR_RELOAD: rdata_nxt = {24'h000000, brg_reload_value_r};
                ADDR_BUFFER: rdata_nxt = {24'h000000, buffer_r};
                ADDR_CONTROL: rdata_nxt = {30'h00000000, i2c_r, enable_r};
                ADDR_STATUS: rdata_nxt = {16'h0000, count, 5'h00,
                    state_r == ST_WAIT_HIGH, sclk_r, state_r != ST_IDLE};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
        if (wr_commit)
        begin
            unique case (address)
                ADDR_RELOAD: reload_nxt = writedata[7:0];
                ADDR_BUFFER: buffer_nxt = writedata[7:0];
                ADDR_CONTROL:
                begin
                    enable_nxt = writedata[CTL_ENABLE_BIT];
                    // mode is held while a byte runs; glitch-free switching
                    if (state_r == ST_IDLE) i2c_nxt = writedata[CTL_I2C_BIT];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
            brg_reload_value_r <= RELOAD_RESET;
            buffer_r <= BUFFER_RESET;
            enable_r <= 1'b0;
            i2c_r <= 1'b0;
        end
        else
        begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
            brg_reload_value_r <= reload_nxt;
            buffer_r <= buffer_nxt;
            enable_r <= enable_nxt;
            i2c_r <= i2c_nxt;
        end
    end

    assign readdata = rdata_r;
    assign serial_shift_buffer = buffer_r;

    // ************************************************************
    // pin sampling: three stages, change taken when 2 and 3 agree
    // ************************************************************
    always_comb
    begin
        pin_high_nxt = pin_high_r;
        if (s2_r == s3_r) pin_high_nxt = s3_r;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            pin_high_r <= 1'b1;
        end
        else
        begin
            s1_r <= sclk_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_high_r <= pin_high_nxt;
        end
    end

    // ************************************************************
    // countdown and half-period sequencing
    // ************************************************************
    serial_clock_divider #(
        .WIDTH(RELOAD_WIDTH)
    ) u_divider (
        .clk(clk),
        .nrst(nrst),
        .load(reload_strobe),
        .step(step_r && state_r == ST_COUNT),
        .reload_value(brg_reload_value_r),
        .count(count),
        .at_zero(at_zero)
    );
    // half period ends on the step that finds zero
    assign half_done = state_r == ST_COUNT && step_r && at_zero;

    always_comb
    begin
        state_nxt = state_r;
        sclk_nxt = sclk_r;
        half_cnt_nxt = half_cnt_r;
        reload_strobe = 1'b0;
        step_nxt = state_r == ST_COUNT ? !step_r : 1'b0;
        unique case (state_r)
            ST_IDLE:
            begin
                if (buf_write && enable_r)
                begin
                    reload_strobe = 1'b1;
                    half_cnt_nxt = 4'h0;
                    state_nxt = ST_COUNT;
                end
            end
            ST_COUNT:
            begin
                if (!enable_r)
                    state_nxt = ST_IDLE;
                else if (half_done)
                begin
                    sclk_nxt = !sclk_r;
                    half_cnt_nxt = half_cnt_r + 4'h1;
                    if (half_cnt_r == 4'(HALVES_PER_BYTE - 1))
                        state_nxt = ST_IDLE;
                    else if (i2c_r && !sclk_r)
                        state_nxt = ST_WAIT_HIGH;
                    else
                        reload_strobe = 1'b1;
                end
            end
            ST_WAIT_HIGH:
            begin
                // a slave may stretch the clock; count starts once seen high
                if (!enable_r)
                    state_nxt = ST_IDLE;
                else if (pin_high_r)
                begin
                    reload_strobe = 1'b1;
                    state_nxt = ST_COUNT;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_r <= ST_IDLE;
            sclk_r <= 1'b0;
            half_cnt_r <= 4'h0;
            step_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            sclk_r <= sclk_nxt;
            half_cnt_r <= half_cnt_nxt;
            step_r <= step_nxt;
        end
    end

    // i2c: open drain, drive only low; spi: push-pull while enabled
    assign sclk_out = sclk_r;
    assign sclk_oe = enable_r && (i2c_r ? !sclk_r : 1'b1);
    assign sclk_edge = half_done;

    // ************************************************************
    // checks
    // ************************************************************
    logic [9:0] half_len_r;
    always_ff @(posedge clk)
    begin
        if (!nrst || sclk_r != sclk_nxt)
            half_len_r <= 10'h000;
        else
            half_len_r <= half_len_r + 10'h001;
    end

    property p_start;
        @(posedge clk) disable iff (!nrst)
        (state_r == ST_IDLE && buf_write && enable_r) |=> state_r == ST_COUNT;
    endproperty
    a_start: assert property (p_start) else $error("buffer write did not start");
    property p_reload;
        @(posedge clk) disable iff (!nrst)
        reload_strobe |=> count == $past(brg_reload_value_r);
    endproperty
    a_reload: assert property (p_reload) else $error("reload value not loaded");
    property p_hold;
        @(posedge clk) disable iff (!nrst)
        (state_r == ST_IDLE && !(buf_write && enable_r)) |=> $stable(sclk_r);
    endproperty
    a_hold: assert property (p_hold) else $error("clock moved while stopped");
    property p_stop;
        @(posedge clk) disable iff (!nrst)
        (half_done && half_cnt_r == 4'(HALVES_PER_BYTE - 1)) |=> state_r == ST_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("no stop after byte");
    property p_spi_reload;
        @(posedge clk) disable iff (!nrst)
        (enable_r && !i2c_r && half_done && half_cnt_r != 4'(HALVES_PER_BYTE - 1))
            |-> reload_strobe;
    endproperty
    a_spi_reload: assert property (p_spi_reload) else $error("missing reload");
    property p_rate;
        @(posedge clk) disable iff (!nrst)
        (!i2c_r && sclk_r != sclk_nxt && half_cnt_r != 4'h0 && $stable(brg_reload_value_r))
            |-> half_len_r == {1'b0, brg_reload_value_r, 1'b1};
    endproperty
    a_rate: assert property (p_rate) else $error("half period length wrong");
    property p_step;
        @(posedge clk) disable iff (!nrst)
        (state_r == ST_COUNT && enable_r && !at_zero) |-> ##2 count == $past(count, 2) - 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("countdown rate wrong");
    property p_enable;
        @(posedge clk) disable iff (!nrst)
        !enable_r |=> state_r == ST_IDLE;
    endproperty
    a_enable: assert property (p_enable) else $error("running while disabled");

endmodule : serial_port_baud_rate_generator

//--- bench/serial_clock_target.sv
`timescale 1ns/10ps

module serial_clock_target
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // setup from the bench
    input wire logic i2c_sel,
    input wire logic [7:0] stretch,
    // serial clock pin
    input wire logic sclk_out,
    input wire logic sclk_oe,
    output logic pin
);
    logic last_r;
    logic [7:0] hold_r;

    // *****************************
    // pin level
    // *****************************
    // spi line has no pull: an undriven wire shows the inverse of its last level
    assign pin = sclk_oe ? sclk_out : (hold_r != 8'h00) ? 1'b0 : (i2c_sel | ~last_r);

    // stretch: keep the line low for a while after the master lets go
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            last_r <= 1'b0;
            hold_r <= 8'h00;
        end
        else
        begin
            if (sclk_oe)
                last_r <= sclk_out;
            if (i2c_sel && sclk_oe)
                hold_r <= stretch;
            else if (hold_r != 8'h00)
                hold_r <= hold_r - 8'h01;
        end
    end
endmodule : serial_clock_target

//--- bench/serial_port_baud_rate_generator_bench.sv
`timescale 1ns/10ps

module serial_port_baud_rate_generator_bench
    import brg_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic sclk_in, sclk_out, sclk_oe, sclk_edge;
    logic [7:0] serial_shift_buffer;
    logic i2c_sel = 1'b0;
    logic [7:0] stretch = 8'h00;
    logic last_lvl = 1'b0;
    logic [31:0] q;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    int toggles = 0;
    int edges = 0;
    int gap_min, gap_max, last_cyc;

    always #20 clk = ~clk;

    serial_port_baud_rate_generator dut_u (.clk(clk), .nrst(nrst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'h1),
        .readdata(readdata), .waitrequest(waitrequest), .sclk_in(sclk_in),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .serial_shift_buffer(serial_shift_buffer),
        .sclk_edge(sclk_edge));

    serial_clock_target far_u (.clk(clk), .nrst(nrst), .i2c_sel(i2c_sel), .stretch(stretch),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .pin(sclk_in));

    // *****************************
    // half-period monitor
    // *****************************
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (sclk_edge === 1'b1)
            edges = edges + 1;
        if (sclk_out !== last_lvl)
        begin
            if (toggles > 0 && cyc - last_cyc < gap_min)
                gap_min = cyc - last_cyc;
            if (toggles > 0 && cyc - last_cyc > gap_max)
                gap_max = cyc - last_cyc;
            toggles = toggles + 1;
            last_cyc = cyc;
            last_lvl = sclk_out;
        end
    end

    // *****************************
    // tasks
    // *****************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic bus(input logic rd, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        address <= a;
        read <= rd;
        write <= !rd;
        writedata <= {24'h000000, d};
        // request stands until waitrequest is seen low at a rising edge
        do
        begin
            @(posedge clk);
        end
        while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    // one byte: program, start, poll until idle, then judge the wave
    task automatic run(input logic [1:0] ctl, input logic [7:0] r, input int exp_t,
        input logic again, input logic [7:0] s);
        logic lvl;
        @(posedge clk);
        i2c_sel <= ctl[CTL_I2C_BIT];
        stretch <= s;
        bus(1'b0, ADDR_RELOAD, r);
        bus(1'b0, ADDR_CONTROL, {6'h00, ctl});
        @(negedge clk);
        toggles = 0;
        edges = 0;
        gap_min = 9999;
        gap_max = 0;
        lvl = sclk_out;
        bus(1'b0, ADDR_BUFFER, 8'ha5);
        if (again)
            bus(1'b0, ADDR_BUFFER, 8'h5a);
        // a byte that never ends is left to the watchdog
        do
        begin
            bus(1'b1, ADDR_STATUS, 8'h00);
        end
        while (q[STS_RUNNING_BIT] !== 1'b0);
        check("status", q, {31'h0, lvl} << STS_SCLK_BIT);
        repeat (8) @(posedge clk);
        check("halves", toggles, exp_t);
        check("edge pulses", edges, exp_t);
        check("level", sclk_out, lvl);
        check("enable", sclk_oe, ctl[CTL_ENABLE_BIT]);
        check("buffer", serial_shift_buffer, again ? 8'h5a : 8'ha5);
        if (exp_t > 0)
            check("low half", gap_min, 2 * (r + 1));
        if (exp_t > 0 && !ctl[CTL_I2C_BIT])
            check("high half", gap_max, 2 * (r + 1));
        if (exp_t > 0 && ctl[CTL_I2C_BIT])
            check("stretched", gap_max >= 2 * (r + 1) + s + 2, 1'b1);
    endtask : run

    task automatic summarize();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // *****************************
    // tests
    // *****************************
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        bus(1'b1, ADDR_RELOAD, 8'h00);
        check("reload reset", q, {24'h0, RELOAD_RESET});
        bus(1'b1, ADDR_BUFFER, 8'h00);
        check("buffer reset", q, {24'h0, BUFFER_RESET});
        bus(1'b0, 4'h6, 8'h77);
        bus(1'b1, 4'h6, 8'h00);
        check("unmapped", q, 32'h0);
        bus(1'b0, ADDR_RELOAD, 8'h3c);
        bus(1'b1, ADDR_RELOAD, 8'h00);
        check("reload", q, 32'h3c);
        bus(1'b0, ADDR_CONTROL, 8'h03);
        bus(1'b1, ADDR_CONTROL, 8'h00);
        check("control", q, 32'h3);
        run(2'b00, 8'h03, 0, 1'b0, 8'h00);
        run(2'b01, 8'h00, 16, 1'b0, 8'h00);
        run(2'b01, 8'h03, 16, 1'b1, 8'h00);
        run(2'b01, 8'hff, 16, 1'b0, 8'h00);
        // lowest reload that the i2c clock may use
        run(2'b11, 8'h03, 16, 1'b0, 8'h00);
        run(2'b11, 8'h04, 16, 1'b0, 8'h14);
        summarize();
    end

    // longest byte is about 8200 cycles; the margin covers the polls
    initial
    begin
        repeat (60000) @(posedge clk);
        errors++;
        summarize();
    end
endmodule : serial_port_baud_rate_generator_bench
